// >>> rtl/lsd_seq.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "lsd_params.svh"

// Notes on behaviour
// - step-down begins with switch-off, minimum output or configured output.
// - minimum output goes as absolute value 1 or relative 100% down step.
// - configured step-down output always goes as absolute brightness value.
// - configured step-down output is 1 to 100 percent, default 50.
// - waiting time is 10 s plus minutes 0..59 and seconds 0..59.
// - dimming to minimum starts the waiting timer; final state after expiry.
// - ignore mode keeps step-down; presence still there at end restarts startup.
// - cancel mode aborts step-down on new presence and starts startup.
// - after waiting, keep minimum output or switch lighting off.
// - final switch-off goes as 1-bit switch or 1-byte value.
// - disable input polarity is selectable.
// - own disable input only standalone; else first function block disables.
// - status output is 1 while disabled or under manual operation.
// - status is sent on every change or only held readable.
// - disable without telegram sends nothing and leaves lighting alone.
// - disable with telegram sends each channel's switch or value telegram.
// - disable with step-down runs step-down and ignores all presence.
// - end of disable resets to OFF, no presence, aborting disable reactions.
// - enable without telegram stays OFF, sends nothing until new presence.
// - enable with switch-off switches lighting off, restarts if presence.
// - enable with startup asserts presence internally to run startup.
module lsd_seq #(
  parameter int TICK_CYCLES = `LSD_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // light control events
  input wire logic ctl_end,
  input wire logic presence,
  input wire logic own_disable,
  input wire logic first_function_block_disable,
  input wire logic manual_active,
  input wire logic [7:0] fb_level,
  // bus side results
  output lsd_pkg::lsd_tg_t tg_o,
  output logic startup_req,
  output logic status_disabled,
  output logic status_tx
);

  // percent clamp
  function automatic logic [6:0] sat_pct(input logic [6:0] p, input logic [6:0] lo);
    return (p < lo) ? lo : ((p > `LSD_PCT_MAX) ? `LSD_PCT_MAX : p);
  endfunction : sat_pct

  // clamp to 59
  function automatic logic [5:0] sat59(input logic [5:0] v);
    return (v > `LSD_MAX59) ? `LSD_MAX59 : v;
  endfunction : sat59

  // percent to bus byte, rounded
  function automatic logic [7:0] pct2byte(input logic [6:0] p);
    logic [15:0] t;
    t = 16'(p) * 16'd255 + 16'd50;
    return 8'(t / 16'd100);
  endfunction : pct2byte

  // switch-off telegram in the chosen format
  function automatic lsd_pkg::lsd_tg_t off_tg(input logic as_byte, input logic [1:0] ch);
    lsd_pkg::lsd_tg_t t;
    t.valid = 1'b1;
    t.kind = as_byte ? lsd_pkg::LSD_TG_VALUE : lsd_pkg::LSD_TG_SWITCH;
    t.chan = ch;
    t.data = 8'h00;
    return t;
  endfunction : off_tg

  // registers
  logic [31:0] cfg_reg;
  logic [31:0] level_reg;
  logic [31:0] wait_reg;
  logic [31:0] chan_reg [0:`LSD_NCH-1];
  logic cap_reg;

  // sequencer state
  lsd_pkg::lsd_state_t state_reg, state_next;
  logic [1:0] ch_reg, ch_next;
  logic sd_reg, sd_next;
  logic dis_q, pres_q, stat_reg, tx_reg, start_reg, start_next;
  lsd_pkg::lsd_tg_t tg_reg, tg_next, sd_tg, ch_tg;
  logic tmr_load, tmr_run, tmr_done;
  logic [11:0] tmr_left;

  // configuration decode
  wire lsd_pkg::lsd_start_t start_mode = lsd_pkg::lsd_start_t'(cfg_reg[`LSD_CFG_START]);
  wire lsd_pkg::lsd_dbeg_t db_mode = lsd_pkg::lsd_dbeg_t'(cfg_reg[`LSD_CFG_DBEG]);
  wire lsd_pkg::lsd_dend_t en_mode = lsd_pkg::lsd_dend_t'(cfg_reg[`LSD_CFG_DEND]);
  wire [6:0] sd_pct = level_reg[`LSD_LVL_PCT];
  wire off_byte = cfg_reg[`LSD_CFG_OFFBYTE];

  // effective disable and status
  wire own_dis = own_disable ^ cfg_reg[`LSD_CFG_POLINV];
  wire dis_eff = cfg_reg[`LSD_CFG_ALONE] ? own_dis : first_function_block_disable;
  wire stat_now = dis_eff | manual_active;
  wire dis_rise = dis_eff & ~dis_q;
  wire dis_fall = ~dis_eff & dis_q;
  wire pres_rise = presence & ~pres_q;
  wire sd_go = (dis_rise & (db_mode == lsd_pkg::LSD_DB_SD))
             | ((state_reg == lsd_pkg::LSD_ST_IDLE) & ctl_end & ~dis_eff);

  // waiting time in seconds: base plus minutes and seconds
  wire [11:0] wait_secs = `LSD_BASE_WAIT_S + 12'(wait_reg[`LSD_WAIT_MIN]) * 12'd60
                        + 12'(wait_reg[`LSD_WAIT_SEC]);

  // telegram at the start of step-down
  always_comb begin
    sd_tg.valid = 1'b1;
    sd_tg.chan = `LSD_CH_ALL;
    sd_tg.kind = lsd_pkg::LSD_TG_VALUE;
    sd_tg.data = `LSD_VAL_MIN;
    case (start_mode)
      lsd_pkg::LSD_SD_OFF: sd_tg = off_tg(off_byte, `LSD_CH_ALL);
      lsd_pkg::LSD_SD_CFG: sd_tg.data = pct2byte(sd_pct);
      lsd_pkg::LSD_SD_MIN: begin
        if (cfg_reg[`LSD_CFG_MINREL]) begin
          sd_tg.kind = lsd_pkg::LSD_TG_DIM;
          sd_tg.data = `LSD_DIM_DOWN_FULL;
        end
      end
      default: sd_tg.valid = 1'b0;
    endcase
  end

  // per-channel disable telegram
  always_comb begin
    ch_tg.valid = 1'b1;
    ch_tg.chan = ch_reg;
    ch_tg.kind = lsd_pkg::LSD_TG_SWITCH;
    ch_tg.data = {7'h00, chan_reg[ch_reg][`LSD_CH_ON]};
    if (chan_reg[ch_reg][`LSD_CH_BYTE]) begin
      ch_tg.kind = lsd_pkg::LSD_TG_VALUE;
      ch_tg.data = pct2byte(chan_reg[ch_reg][`LSD_CH_PCT]);
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    ch_next = ch_reg;
    sd_next = sd_reg;
    tg_next = '0;
    start_next = 1'b0;
    tmr_load = 1'b0;
    if (dis_fall) begin
      sd_next = 1'b0;
      ch_next = 2'h0;
      state_next = lsd_pkg::LSD_ST_IDLE;
      if (en_mode == lsd_pkg::LSD_EN_OFF) state_next = lsd_pkg::LSD_ST_EN_OFF;
      if (en_mode == lsd_pkg::LSD_EN_START) start_next = 1'b1;
    end else if (dis_rise & (db_mode != lsd_pkg::LSD_DB_SD)) begin
      ch_next = 2'h0;
      state_next = (db_mode == lsd_pkg::LSD_DB_TG) ? lsd_pkg::LSD_ST_DIS_SEND
                                                  : lsd_pkg::LSD_ST_DISABLED;
    end else if (sd_go) begin
      tg_next = sd_tg;
      sd_next = dis_rise;
      if (start_mode == lsd_pkg::LSD_SD_OFF) begin
        state_next = dis_rise ? lsd_pkg::LSD_ST_DISABLED : lsd_pkg::LSD_ST_IDLE;
      end else begin
        tmr_load = 1'b1;
        state_next = lsd_pkg::LSD_ST_WAIT;
      end
    end else begin
      case (state_reg)
        lsd_pkg::LSD_ST_WAIT: begin
          if (pres_rise & cfg_reg[`LSD_CFG_CANCEL] & ~sd_reg) begin
            start_next = 1'b1;
            state_next = lsd_pkg::LSD_ST_IDLE;
          end else if (tmr_done) begin
            if (cfg_reg[`LSD_CFG_ENDOFF]) tg_next = off_tg(off_byte, `LSD_CH_ALL);
            start_next = presence & ~sd_reg;
            state_next = sd_reg ? lsd_pkg::LSD_ST_DISABLED : lsd_pkg::LSD_ST_IDLE;
          end
        end
        lsd_pkg::LSD_ST_DIS_SEND: begin
          tg_next = ch_tg;
          ch_next = ch_reg + 2'h1;
          if (ch_reg == 2'(`LSD_NCH - 1)) begin
            ch_next = 2'h0; // keeps the channel index inside the table
            state_next = lsd_pkg::LSD_ST_DISABLED;
          end
        end
        lsd_pkg::LSD_ST_EN_OFF: begin
          tg_next = off_tg(1'b0, ch_reg);
          ch_next = ch_reg + 2'h1;
          if (ch_reg == 2'(`LSD_NCH - 1)) begin
            ch_next = 2'h0;
            start_next = presence;
            state_next = lsd_pkg::LSD_ST_IDLE;
          end
        end
        default: state_next = state_reg;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lsd_pkg::LSD_ST_IDLE;
      ch_reg <= 2'h0;
      sd_reg <= 1'b0;
      tg_reg <= '0;
      start_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      ch_reg <= ch_next;
      sd_reg <= sd_next;
      tg_reg <= tg_next;
      start_reg <= start_next;
    end
  end

  // edge history and disable status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_q <= 1'b0;
      pres_q <= 1'b0;
      stat_reg <= 1'b0;
      tx_reg <= 1'b0;
    end else if (ce) begin
      dis_q <= dis_eff;
      pres_q <= presence & ~dis_fall;
      stat_reg <= stat_now;
      tx_reg <= cfg_reg[`LSD_CFG_STACT] & (stat_now != stat_reg);
    end
  end

  // waiting timer
  lsd_sec_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(tmr_load),
    .secs(wait_secs),
    .running(tmr_run),
    .done(tmr_done),
    .remain(tmr_left)
  );

  // apb decode
  wire [2:0] idx = paddr[4:2];
  wire mapped = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0) & (idx <= `LSD_IDX_LAST);
  wire wr = psel & penable & pwrite & pready & mapped;
  wire [31:0] status_word = {4'h0, tmr_left, fb_level, 2'h0, tmr_run, sd_reg,
                             stat_reg, state_reg};
  wire [31:0] rdata = (paddr == `LSD_OFS_CFG) ? cfg_reg
                    : (paddr == `LSD_OFS_LEVEL) ? level_reg
                    : (paddr == `LSD_OFS_WAIT) ? wait_reg
                    : (paddr == `LSD_OFS_STATUS) ? status_word
                    : (mapped & (idx >= 3'h3)) ? chan_reg[2'(idx - 3'h3)]
                    : 32'h0000_0000;
  assign pready = ce & cap_reg;
  assign pslverr = psel & penable & ~mapped;

  // register writes and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `LSD_CFG_RST;
      level_reg <= `LSD_LEVEL_RST;
      wait_reg <= `LSD_WAIT_RST;
      for (int i = 0; i < `LSD_NCH; i++) chan_reg[i] <= `LSD_CHAN_RST;
      prdata <= 32'h0000_0000;
      cap_reg <= 1'b0;
    end else if (ce) begin
      cap_reg <= psel;
      if (psel) prdata <= rdata;
      if (wr & (paddr == `LSD_OFS_CFG)) cfg_reg <= pwdata & `LSD_CFG_MASK;
      if (wr & (paddr == `LSD_OFS_LEVEL)) begin
        level_reg <= {25'h0, sat_pct(pwdata[6:0], `LSD_PCT_MIN)};
      end
      if (wr & (paddr == `LSD_OFS_WAIT)) begin
        wait_reg <= {18'h0, sat59(pwdata[13:8]), 2'h0, sat59(pwdata[5:0])};
      end
      // status word is read-only, so channel writes stop below it
      if (wr & (paddr >= `LSD_OFS_CHAN0) & (paddr < `LSD_OFS_STATUS)) begin
        chan_reg[2'(idx - 3'h3)] <= {17'h0, sat_pct(pwdata[14:8], 7'h00), 6'h0, pwdata[1:0]};
      end
    end
  end

  // outputs
  assign tg_o = '{valid: tg_reg.valid & ce, kind: tg_reg.kind, chan: tg_reg.chan,
                  data: tg_reg.data};
  assign startup_req = start_reg & ce;
  assign status_disabled = stat_reg;
  assign status_tx = tx_reg & ce;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_burst_start;
    ce && dis_rise && db_mode == lsd_pkg::LSD_DB_TG;
  endsequence
  sequence s_burst_run;
    (ce && dis_eff)[*3];
  endsequence

  a_cfg_output_abs: assert property (
    ce && sd_go && !dis_fall && start_mode == lsd_pkg::LSD_SD_CFG
    |=> tg_reg.valid && tg_reg.kind == lsd_pkg::LSD_TG_VALUE
        && tg_reg.data == pct2byte($past(sd_pct)))
    else $error("configured step-down output wrong");
  a_min_rel_step: assert property (
    ce && sd_go && !dis_fall && start_mode == lsd_pkg::LSD_SD_MIN && cfg_reg[`LSD_CFG_MINREL]
    |=> tg_reg.kind == lsd_pkg::LSD_TG_DIM && tg_reg.data == 8'h01)
    else $error("minimum output not a full down step");
  a_wait_entry: assert property (
    ce && sd_go && !dis_fall && start_mode != lsd_pkg::LSD_SD_OFF
    |=> state_reg == lsd_pkg::LSD_ST_WAIT && tmr_run)
    else $error("waiting timer not started");
  a_cancel_start: assert property (
    ce && state_reg == lsd_pkg::LSD_ST_WAIT && pres_rise && cfg_reg[`LSD_CFG_CANCEL]
    && !sd_reg && !dis_fall && !dis_rise
    |=> startup_req && state_reg == lsd_pkg::LSD_ST_IDLE)
    else $error("cancel mode did not restart startup");
  a_ignore_hold: assert property (
    ce && state_reg == lsd_pkg::LSD_ST_WAIT && !cfg_reg[`LSD_CFG_CANCEL] && !tmr_done
    && !dis_fall && !dis_rise |=> state_reg == lsd_pkg::LSD_ST_WAIT && !startup_req)
    else $error("ignore mode left waiting early");
  a_end_switch_off: assert property (
    ce && state_reg == lsd_pkg::LSD_ST_WAIT && tmr_done && cfg_reg[`LSD_CFG_ENDOFF]
    && !dis_fall && !dis_rise && !(pres_rise && cfg_reg[`LSD_CFG_CANCEL] && !sd_reg)
    |=> tg_reg.valid && tg_reg.data == 8'h00 && tg_reg.kind == (off_byte ?
        lsd_pkg::LSD_TG_VALUE : lsd_pkg::LSD_TG_SWITCH))
    else $error("final switch-off missing");
  a_disable_silent: assert property (
    ce && dis_rise && !dis_fall && db_mode == lsd_pkg::LSD_DB_NONE
    |=> !tg_reg.valid && state_reg == lsd_pkg::LSD_ST_DISABLED)
    else $error("silent disable sent a telegram");
  a_burst_done: assert property (
    s_burst_start ##1 s_burst_run |=> state_reg == lsd_pkg::LSD_ST_DISABLED)
    else $error("channel telegrams not finished");
  a_enable_abort: assert property (
    ce && dis_fall |=> !sd_reg && state_reg != lsd_pkg::LSD_ST_WAIT && !pres_q)
    else $error("disable reaction not aborted");
  a_status_follow: assert property (
    ce |=> status_disabled == $past(stat_now))
    else $error("disable status stale");
  a_status_passive: assert property (
    !cfg_reg[`LSD_CFG_STACT] && ce |=> !tx_reg)
    else $error("passive status was sent");

endmodule : lsd_seq

// >>> rtl/lsd_params.svh
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

// register byte offsets
`define LSD_OFS_CFG 8'h00
`define LSD_OFS_LEVEL 8'h04
`define LSD_OFS_WAIT 8'h08
`define LSD_OFS_CHAN0 8'h0C
`define LSD_OFS_STATUS 8'h18
`define LSD_IDX_LAST 3'h6

// configuration fields
`define LSD_CFG_START 1:0
`define LSD_CFG_MINREL 2
`define LSD_CFG_CANCEL 3
`define LSD_CFG_ENDOFF 4
`define LSD_CFG_OFFBYTE 5
`define LSD_CFG_POLINV 6
`define LSD_CFG_ALONE 7
`define LSD_CFG_STACT 8
`define LSD_CFG_DBEG 10:9
`define LSD_CFG_DEND 12:11
`define LSD_CFG_MASK 32'h0000_1FFF

// level, wait and channel fields
`define LSD_LVL_PCT 6:0
`define LSD_WAIT_MIN 5:0
`define LSD_WAIT_SEC 13:8
`define LSD_CH_BYTE 0
`define LSD_CH_ON 1
`define LSD_CH_PCT 14:8

// reset values
`define LSD_CFG_RST 32'h0000_0081
`define LSD_LEVEL_RST 32'h0000_0032
`define LSD_WAIT_RST 32'h0000_0000
`define LSD_CHAN_RST 32'h0000_0000

// values and counts
`define LSD_NCH 3
`define LSD_CH_ALL 2'h3
`define LSD_PCT_MAX 7'h64
`define LSD_PCT_MIN 7'h01
`define LSD_MAX59 6'h3B
`define LSD_VAL_MIN 8'h01
`define LSD_DIM_DOWN_FULL 8'h01
`define LSD_BASE_WAIT_S 12'h00A
`define LSD_CLK_KHZ 25000
`define LSD_TICK_MS 1000
`define LSD_TICK_CYCLES (`LSD_TICK_MS * `LSD_CLK_KHZ)

`endif

// >>> rtl/lsd_pkg.sv
package lsd_pkg;

  typedef enum logic [2:0] {
    LSD_ST_IDLE = 3'b000,
    LSD_ST_WAIT = 3'b001,
    LSD_ST_DIS_SEND = 3'b010,
    LSD_ST_DISABLED = 3'b011,
    LSD_ST_EN_OFF = 3'b100
  } lsd_state_t;

  typedef enum logic [1:0] {
    LSD_SD_OFF = 2'b00,
    LSD_SD_MIN = 2'b01,
    LSD_SD_CFG = 2'b10
  } lsd_start_t;

  typedef enum logic [1:0] {
    LSD_DB_NONE = 2'b00,
    LSD_DB_TG = 2'b01,
    LSD_DB_SD = 2'b10
  } lsd_dbeg_t;

  typedef enum logic [1:0] {
    LSD_EN_NONE = 2'b00,
    LSD_EN_OFF = 2'b01,
    LSD_EN_START = 2'b10
  } lsd_dend_t;

  typedef enum logic [1:0] {
    LSD_TG_SWITCH = 2'b00,
    LSD_TG_VALUE = 2'b01,
    LSD_TG_DIM = 2'b10
  } lsd_tg_kind_t;

  typedef struct packed {
    logic valid;
    lsd_tg_kind_t kind;
    logic [1:0] chan;
    logic [7:0] data;
  } lsd_tg_t;

endpackage : lsd_pkg

// >>> rtl/lsd_sec_timer.sv
`timescale 1ns/10ps
`include "lsd_params.svh"

module lsd_sec_timer #(
  parameter int TICK_CYCLES = `LSD_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [11:0] secs,
  // status
  output logic running,
  output logic done,
  output logic [11:0] remain
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  logic [PW-1:0] pre_reg;
  logic [11:0] left_reg;
  logic run_reg;

  // one second tick from the prescaler
  wire tick = run_reg & (pre_reg == PW'(TICK_CYCLES - 1));
  assign done = ce & tick & (left_reg == 12'h001);
  assign running = run_reg;
  assign remain = left_reg;

  // prescaler and seconds counter, reloaded on load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
      left_reg <= 12'h000;
      run_reg <= 1'b0;
    end else if (ce) begin
      if (load) begin
        pre_reg <= '0;
        left_reg <= secs;
        run_reg <= (secs != 12'h000);
      end else if (run_reg) begin
        pre_reg <= tick ? '0 : pre_reg + 1'b1;
        if (tick) left_reg <= left_reg - 12'h001;
        if (done) run_reg <= 1'b0;
      end
    end
  end

endmodule : lsd_sec_timer

// >>> tb/lsd_actuator.sv
`timescale 1ns/10ps

module lsd_actuator #(
  parameter int DELAY = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // telegrams from the controller
  input wire lsd_pkg::lsd_tg_t tg_i,
  // brightness feedback of channel one
  output logic [7:0] fb_level
);
  logic [7:0] target_reg;
  int lag;

  // channel one dimmer, settles some cycles after each telegram, not at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reg <= 8'h00;
      lag <= 0;
      fb_level <= 8'h00;
    end else if (tg_i.valid === 1'b1 && (tg_i.chan == 2'h0 || tg_i.chan == 2'h3)) begin
      lag <= DELAY;
      case (tg_i.kind)
        lsd_pkg::LSD_TG_SWITCH: target_reg <= tg_i.data[0] ? 8'hFF : 8'h00;
        lsd_pkg::LSD_TG_VALUE: target_reg <= tg_i.data;
        default: target_reg <= (fb_level == 8'h00) ? 8'h00 : 8'h01; // full step down
      endcase
    end else if (lag != 0) begin
      lag <= lag - 1;
    end else begin
      fb_level <= target_reg; // brightness fed back
    end
  end
endmodule : lsd_actuator

// >>> tb/light_control_stepdown_disable_tb.sv
`timescale 1ns/10ps
`include "lsd_params.svh"

module light_control_stepdown_disable_tb;
  localparam int T = 4;
  localparam lsd_pkg::lsd_tg_kind_t SW = lsd_pkg::LSD_TG_SWITCH;
  localparam lsd_pkg::lsd_tg_kind_t VA = lsd_pkg::LSD_TG_VALUE;
  localparam lsd_pkg::lsd_tg_kind_t DM = lsd_pkg::LSD_TG_DIM;
  // dut signals
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic ctl_end, presence, own_disable, first_function_block_disable, manual_active;
  logic startup_req, status_disabled, status_tx;
  logic [7:0] paddr, fb_level;
  logic [31:0] pwdata, prdata, r;
  logic e;
  lsd_pkg::lsd_tg_t tg_o;
  // scoreboard
  logic [11:0] seen_q[$], exp_q[$];
  int st_q[$];
  int cyc = 0, su_cnt = 0, tx_cnt = 0, bad_count = 0, total_checks = 0;
  int seed = 32'h0000_f2da;

  lsd_seq #(.TICK_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctl_end(ctl_end), .presence(presence),
    .own_disable(own_disable), .first_function_block_disable(first_function_block_disable),
    .manual_active(manual_active), .fb_level(fb_level), .tg_o(tg_o),
    .startup_req(startup_req), .status_disabled(status_disabled), .status_tx(status_tx));
  lsd_actuator #(.DELAY(3)) act (.pclk(pclk), .presetn(presetn), .tg_i(tg_o),
    .fb_level(fb_level));

  // clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // collect telegrams and pulses of the dut
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tg_o.valid === 1'b1) begin
      seen_q.push_back({tg_o.kind, tg_o.chan, tg_o.data});
      st_q.push_back(cyc);
    end
    if (startup_req === 1'b1) su_cnt <= su_cnt + 1;
    if (status_tx === 1'b1) tx_cnt <= tx_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step

  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : look

  // one apb transfer, waits for pready, result in r and e
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic ctl_pulse;
    step(1);
    ctl_end <= 1'b1;
    step(1);
    ctl_end <= 1'b0;
  endtask : ctl_pulse

  task automatic tgwait(input int cnt);
    int n;
    n = 0;
    while (seen_q.size() < cnt && n < 600) begin
      @(negedge pclk);
      n++;
    end
  endtask : tgwait

  task automatic match_q;
    check(32'(seen_q.size()), 32'(exp_q.size()), "telegram count");
    foreach (exp_q[k]) if (k < seen_q.size()) check({20'h0, seen_q[k]}, {20'h0, exp_q[k]}, "tg");
    seen_q.delete();
    exp_q.delete();
    st_q.delete();
  endtask : match_q

  task automatic st_chk(input logic want);
    look(3);
    check({31'h0, status_disabled}, {31'h0, want}, "disable status");
  endtask : st_chk

  task automatic pollidle;
    int n;
    n = 0;
    do begin
      rd(`LSD_OFS_STATUS);
      n++;
    end while (r[2:0] !== 3'h0 && n < 200);
    check(32'(n < 200), 32'h0000_0001, "back to idle");
  endtask : pollidle

  function automatic logic [11:0] tgv(input lsd_pkg::lsd_tg_kind_t k, input logic [1:0] c,
    input logic [7:0] d);
    return {k, c, d};
  endfunction : tgv

  function automatic logic [31:0] cfgw(input int st, mr, cn, eo, ob, pi, al, sa, db, de);
    return 32'(st | mr << 2 | cn << 3 | eo << 4 | ob << 5 | pi << 6 | al << 7 | sa << 8
      | db << 9 | de << 11);
  endfunction : cfgw

  // watchdog
  initial begin
    step(20000);
    bad_count++;
    complete_run();
  end

  // main sequence
  initial begin
    int w, s, p, n;
    {psel, penable, pwrite, ctl_end, presence, own_disable, manual_active} = '0;
    first_function_block_disable = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ce = 1'b1;
    presetn = 1'b0;
    step(2);
    presetn <= 1'b1;
    // reset values, clamps, unmapped place
    rd(`LSD_OFS_CFG);
    check(r, 32'h0000_0081, "cfg reset");
    rd(`LSD_OFS_LEVEL);
    check(r, 32'h0000_0032, "level reset");
    wr(`LSD_OFS_LEVEL, 32'h0000_0000);
    rd(`LSD_OFS_LEVEL);
    check(r, 32'h0000_0001, "level low clamp");
    wr(`LSD_OFS_WAIT, 32'h0000_3F3F);
    rd(`LSD_OFS_WAIT);
    check(r, 32'h0000_3B3B, "wait clamp");
    rd(8'h1C);
    check({e, r[30:0]}, 32'h8000_0000, "unmapped read");
    // every step-down start action, random level and waiting time
    for (int i = 0; i < 4; i++) begin
      s = $unsigned($random(seed)) % 6;
      w = 10 + s + ((i == 3) ? 60 : 0);
      p = 1 + $unsigned($random(seed)) % 100;
      wr(`LSD_OFS_LEVEL, 32'(p));
      wr(`LSD_OFS_WAIT, 32'(s << 8 | (i == 3)));
      wr(`LSD_OFS_CFG, cfgw((i == 0) ? 0 : ((i == 3) ? 2 : 1), i == 2, 0, 1, i & 1, 0, 1, 0, 0, 0));
      case (i)
        0: exp_q.push_back(tgv(SW, 2'h3, 8'h00));
        1: exp_q.push_back(tgv(VA, 2'h3, 8'h01));
        2: exp_q.push_back(tgv(DM, 2'h3, 8'h01));
        default: exp_q.push_back(tgv(VA, 2'h3, 8'((p * 255 + 50) / 100)));
      endcase
      if (i != 0) exp_q.push_back(tgv((i & 1) ? VA : SW, 2'h3, 8'h00));
      ctl_pulse();
      tgwait(1);
      look(8);
      rd(`LSD_OFS_STATUS);
      if (i & 1) check({24'h0, r[15:8]}, {24'h0, exp_q[0][7:0]}, "feedback");
      tgwait(exp_q.size());
      if (i != 0) check(32'(st_q.size() > 1 && st_q[1] - st_q[0] >= (w - 1) * T
        && st_q[1] - st_q[0] <= w * T + 3), 32'h0000_0001, "wait length");
      match_q();
      look(3);
    end
    // ignore mode, keep output
    wr(`LSD_OFS_WAIT, 32'h0000_0000);
    wr(`LSD_OFS_CFG, cfgw(1, 0, 0, 0, 0, 0, 1, 0, 0, 0));
    n = su_cnt;
    ctl_pulse();
    step(5);
    presence <= 1'b1;
    look(10);
    check(32'(su_cnt - n), 32'h0000_0000, "presence ignored");
    pollidle();
    check(32'(su_cnt - n), 32'h0000_0001, "restart at end");
    exp_q.push_back(tgv(VA, 2'h3, 8'h01));
    match_q();
    step(1);
    presence <= 1'b0;
    // cancel mode
    wr(`LSD_OFS_CFG, cfgw(1, 0, 1, 1, 0, 0, 1, 0, 0, 0));
    n = su_cnt;
    ctl_pulse();
    step(8);
    presence <= 1'b1;
    look(4);
    check(32'(su_cnt - n), 32'h0000_0001, "cancel restarts");
    look(50);
    exp_q.push_back(tgv(VA, 2'h3, 8'h01));
    match_q();
    step(1);
    presence <= 1'b0;
    // disable source, polarity and status
    wr(`LSD_OFS_CFG, cfgw(1, 0, 0, 1, 0, 0, 1, 1, 0, 0));
    n = tx_cnt;
    step(1);
    first_function_block_disable <= 1'b1;
    st_chk(1'b0);
    step(1);
    own_disable <= 1'b1;
    st_chk(1'b1);
    step(1);
    own_disable <= 1'b0;
    st_chk(1'b0);
    step(1);
    manual_active <= 1'b1;
    st_chk(1'b1);
    step(1);
    manual_active <= 1'b0;
    st_chk(1'b0);
    check(32'(tx_cnt - n), 32'h0000_0004, "status sent");
    wr(`LSD_OFS_CFG, cfgw(1, 0, 0, 1, 0, 1, 1, 1, 0, 0));
    st_chk(1'b1);
    wr(`LSD_OFS_CFG, cfgw(1, 0, 0, 1, 0, 0, 0, 0, 0, 0));
    n = tx_cnt;
    st_chk(1'b1);
    step(1);
    first_function_block_disable <= 1'b0;
    st_chk(1'b0);
    check(32'(tx_cnt - n), 32'h0000_0000, "passive status");
    match_q();
    // disable with telegram, enable with switch-off
    wr(`LSD_OFS_CHAN0, 32'h0000_7F01);
    rd(`LSD_OFS_CHAN0);
    check(r, 32'h0000_6401, "channel clamp");
    wr(`LSD_OFS_CHAN0, 32'h0000_0001);
    wr(`LSD_OFS_CHAN0 + 8'h04, 32'h0000_0002);
    wr(`LSD_OFS_CHAN0 + 8'h08, 32'h0000_0000);
    wr(`LSD_OFS_CFG, cfgw(1, 0, 0, 1, 0, 0, 1, 0, 1, 1));
    n = su_cnt;
    step(1);
    own_disable <= 1'b1;
    tgwait(3);
    check(32'(st_q.size() > 2 && st_q[2] - st_q[0] == 2), 32'h0000_0001, "back to back");
    exp_q.push_back(tgv(VA, 2'h0, 8'h00));
    exp_q.push_back(tgv(SW, 2'h1, 8'h01));
    exp_q.push_back(tgv(SW, 2'h2, 8'h00));
    match_q();
    step(1);
    presence <= 1'b1;
    step(2);
    own_disable <= 1'b0;
    tgwait(3);
    look(4);
    for (int c = 0; c < 3; c++) exp_q.push_back(tgv(SW, 2'(c), 8'h00));
    match_q();
    check(32'(su_cnt - n), 32'h0000_0001, "restart after enable");
    step(1);
    presence <= 1'b0;
    // disable with step-down aborted by enable with startup
    wr(`LSD_OFS_CFG, cfgw(1, 0, 1, 1, 0, 0, 1, 0, 2, 2));
    n = su_cnt;
    step(1);
    own_disable <= 1'b1;
    tgwait(1);
    step(2);
    presence <= 1'b1;
    step(3);
    presence <= 1'b0;
    look(10);
    check(32'(su_cnt - n), 32'h0000_0000, "presence while disabled");
    exp_q.push_back(tgv(VA, 2'h3, 8'h01));
    match_q();
    step(1);
    own_disable <= 1'b0;
    look(60);
    check(32'(su_cnt - n), 32'h0000_0001, "startup on enable");
    match_q();
    rd(`LSD_OFS_STATUS);
    check({29'h0, r[2:0]}, 32'h0000_0000, "off after enable");
    complete_run();
  end
endmodule : light_control_stepdown_disable_tb
